//--- include/ncsr_defines.vh
// Purpose: constants of the nonvolatile configuration save/restore block
// Assumes: 200 MHz system clock
// Notes:   timing counts are derived from the printed times
`ifndef NCSR_DEFINES_VH
`define NCSR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets and field positions
// ----------------------------------------------------------------
`define NCSR_REG_STATUS 12'hb00
`define NCSR_REG_ERROR 12'hb01
`define NCSR_REG_WEN 12'hb02
`define NCSR_REG_SAVE 12'hb03
`define NCSR_SEG_BASE 12'ha00
`define NCSR_SEG_LEN 23
`define NCSR_BIT_BUSY 0
`define NCSR_BIT_ERR 0
`define NCSR_BIT_WEN 0
`define NCSR_BIT_SOFTLD 1
`define NCSR_BIT_SAVE 0
`define NCSR_RST_BYTE 8'h00

// ----------------------------------------------------------------
// operation codes and special register
// ----------------------------------------------------------------
`define NCSR_OP_COMMIT 8'h80
`define NCSR_OP_END 8'hff
`define NCSR_OP_PEND 8'hfe
`define NCSR_CAL_ADDR 16'h00f3
`define NCSR_CAL_BIT 1

// ----------------------------------------------------------------
// store size and timing
// ----------------------------------------------------------------
`define NCSR_NVM_BYTES 512
`define NCSR_CLK_MHZ 200
`define NCSR_SAVE_MS 46
`define NCSR_LOAD_MS 40
`define NCSR_DEF_US 2
`define NCSR_SAVE_BYTE_CYC ((`NCSR_SAVE_MS*1000*`NCSR_CLK_MHZ)/`NCSR_NVM_BYTES)
`define NCSR_LOAD_BYTE_CYC ((`NCSR_LOAD_MS*1000*`NCSR_CLK_MHZ)/`NCSR_NVM_BYTES)
`define NCSR_DEF_CYC (`NCSR_DEF_US*`NCSR_CLK_MHZ)

// ----------------------------------------------------------------
// power-up buffer segment: groups 0x000..0x1cf and 0x220..0x234, commit, end
// ----------------------------------------------------------------
`define NCSR_SEG_DEFAULT {8'h7f, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h80, \
   8'h7f, 8'h01, 8'h00, 8'h4f, 8'h01, 8'h80, 8'h14, 8'h02, 8'h20, \
   8'h80, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}

`endif

//--- design/ncsr_nvm_config_save_restore.v
// Purpose: save register configuration to an on-chip store and restore it
// Assumes: serial-port framing is decoded outside; inputs are synchronous
// Notes:   one state machine walks the buffer segment or the stored image
`include "ncsr_defines.vh"

// What this block does
// - a 512-byte store holds the user setting file used at reset
// - while a transfer runs only the busy flag at 0xb00 is reachable
// - busy flag goes to 1 at transfer start and 0 at its end
// - slave address is not acknowledged while a transfer runs
// - with 0x232 bit 4 set the busy flag drives the first status pin
// - full save takes about 46 ms, full load about 40 ms
// - hard reset loads stored settings if boot-select is 1, else defaults
// - every hard reset also issues an output phase-alignment
// - outputs start about 2 us after reset, or after the load
// - the serial port can never write the store directly
// - save-start copies registers and segment bytes, then clears itself
// - a failed save or load sets the data-error flag at 0xb01 bit 0
// - boot-select high: load on power-up, reset release or soft reset
// - boot-select low: defaults at reset; soft-load bit still loads
// - stored calibrate bit at 0x0f3 bit 1 starts calibration after load
// - power-up segment stores registers 0x000 to 0x1cf and 0x220 to 0x234
// - group first byte is byte count minus one, at most 128
// - group bytes two and three are address high then low
// - codes: 0x80 commit, 0xff end, 0xfe pseudo end
// - commit code during a load copies buffer bank to active bank
// - pseudo end halts a save; next save plus commit resumes address
module ncsr_nvm_config_save_restore #(
   parameter [23:0] P_SAVE_BYTE_CYC = `NCSR_SAVE_BYTE_CYC,
   parameter [23:0] P_LOAD_BYTE_CYC = `NCSR_LOAD_BYTE_CYC,
   parameter FIFO_W = 24
) (
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_boot_sel,
   input wire i_soft_reset,
   input wire i_commit,
   input wire i_first_status_output_sel,
   input wire i_first_status_output_other,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [11:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   output wire [7:0] o_reg_rdata,
   output wire o_reg_ack,
   output wire o_port_blocked,
   output wire o_i2c_addr_ack,
   output wire o_first_status_output,
   output wire [15:0] o_cfg_raddr,
   input wire [7:0] i_cfg_rdata,
   output wire o_cfg_wvalid,
   output wire [15:0] o_cfg_waddr,
   output wire [7:0] o_cfg_wdata,
   input wire i_cfg_wready,
   output wire o_commit,
   output wire o_load_defaults,
   output wire o_phase_align,
   output wire o_cal_start,
   output wire o_outputs_on
);

   // ----------------------------------------------------------------
   // states and entry kinds
   // ----------------------------------------------------------------
   localparam [4:0] ST_BOOT = 5'h01;
   localparam [4:0] ST_IDLE = 5'h02;
   localparam [4:0] ST_DEFW = 5'h04;
   localparam [4:0] ST_SAVE = 5'h08;
   localparam [4:0] ST_LOAD = 5'h10;
   localparam [2:0] K_GRP = 3'h0;
   localparam [2:0] K_COMMIT = 3'h1;
   localparam [2:0] K_END = 3'h2;
   localparam [2:0] K_PEND = 3'h3;
   localparam [2:0] K_BAD = 3'h4;
   localparam [9:0] NVM_TOP = `NCSR_NVM_BYTES;
   localparam [4:0] SEG_TOP = `NCSR_SEG_LEN;
   localparam [23:0] DEF_CYC = `NCSR_DEF_CYC;
   localparam [183:0] SEG_DEF = `NCSR_SEG_DEFAULT;

   // classify one segment or store byte, shared by save and load
   function [2:0] f_kind;
      input [7:0] b;
      begin
         if (b == `NCSR_OP_COMMIT)
            f_kind = K_COMMIT;
         else if (b == `NCSR_OP_END)
            f_kind = K_END;
         else if (b == `NCSR_OP_PEND)
            f_kind = K_PEND;
         else if (!b[7])
            f_kind = K_GRP;
         else
            f_kind = K_BAD;
      end
   endfunction

   reg [4:0] state_ff;
   reg [1:0] phase_ff;
   reg [4:0] sidx_ff;
   reg [9:0] nptr_ff;
   reg [6:0] cnt_ff;
   reg [15:0] raddr_ff;
   reg [23:0] wait_ff;
   reg err_ff;
   reg wen_ff;
   reg save_ff;
   reg resume_ff;
   reg cal_ff;
   reg reset_load_ff;
   reg outputs_on_ff;
   reg commit_ff;
   reg defl_ff;
   reg align_ff;
   reg cal_start_ff;
   reg [7:0] rdata_ff;
   reg ack_ff;
   reg [7:0] seg_ff [0:`NCSR_SEG_LEN-1];
   reg [7:0] nvm_mem [0:`NCSR_NVM_BYTES-1];
   reg [FIFO_W-1:0] fq_ff [0:1];
   reg fwp_ff;
   reg frp_ff;
   reg [1:0] fcnt_ff;
   reg [7:0] rd_mux;
   integer i;

   // ----------------------------------------------------------------
   // decode of current step
   // ----------------------------------------------------------------
   wire busy = (state_ff == ST_SAVE) || (state_ff == ST_LOAD);
   wire tick = (wait_ff == 24'h000000);
   wire [7:0] sv_seg = seg_ff[sidx_ff];
   wire [7:0] ld_byte = nvm_mem[nptr_ff[8:0]];
   wire [7:0] cur_byte = (state_ff == ST_LOAD) ? ld_byte : sv_seg;
   wire [2:0] kind = f_kind(cur_byte);
   wire [11:0] seg_off = i_reg_addr - `NCSR_SEG_BASE;
   wire in_seg = (i_reg_addr >= `NCSR_SEG_BASE) &&
                 (seg_off < {7'h00, SEG_TOP});
   // writes are dropped while a transfer runs
   wire sw_wr = i_reg_wr && !busy;
   wire softld_req = sw_wr && (i_reg_addr == `NCSR_REG_WEN) &&
                     i_reg_wdata[`NCSR_BIT_SOFTLD];
   wire fifo_full = (fcnt_ff == 2'd2);
   wire fifo_empty = (fcnt_ff == 2'd0);
   wire fifo_pop = o_cfg_wvalid && i_cfg_wready;
   wire sv_step = (state_ff == ST_SAVE) && tick;
   // a data byte waits for buffer room, commit and end wait for drain
   wire ld_stall = (phase_ff == 2'd3) ? fifo_full :
                   ((phase_ff == 2'd0) && (kind == K_COMMIT ||
                    kind == K_END) && !fifo_empty);
   wire ld_step = (state_ff == ST_LOAD) && tick && !ld_stall;
   wire fifo_push = ld_step && (phase_ff == 2'd3);
   wire nvm_full = (nptr_ff == NVM_TOP);
   wire [23:0] byte_cyc = (state_ff == ST_LOAD) ? P_LOAD_BYTE_CYC :
                          P_SAVE_BYTE_CYC;

   // ----------------------------------------------------------------
   // main sequencer
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      commit_ff <= 1'b0;
      defl_ff <= 1'b0;
      align_ff <= 1'b0;
      cal_start_ff <= 1'b0;
      if (!i_rstn) begin
         state_ff <= ST_BOOT;
         phase_ff <= 2'd0;
         sidx_ff <= 5'h00;
         nptr_ff <= 10'h000;
         cnt_ff <= 7'h00;
         raddr_ff <= 16'h0000;
         wait_ff <= 24'h000000;
         err_ff <= 1'b0;
         wen_ff <= 1'b0;
         save_ff <= 1'b0;
         resume_ff <= 1'b0;
         cal_ff <= 1'b0;
         reset_load_ff <= 1'b0;
         outputs_on_ff <= 1'b0;
         for (i = 0; i < `NCSR_SEG_LEN; i = i + 1) begin
            seg_ff[i] <= SEG_DEF[(`NCSR_SEG_LEN-1-i)*8 +: 8];
         end
      end else begin
         // register writes from the serial side; store is not mapped
         if (sw_wr) begin
            if (in_seg)
               seg_ff[seg_off[4:0]] <= i_reg_wdata;
            if (i_reg_addr == `NCSR_REG_WEN)
               wen_ff <= i_reg_wdata[`NCSR_BIT_WEN];
            if (i_reg_addr == `NCSR_REG_SAVE)
               save_ff <= i_reg_wdata[`NCSR_BIT_SAVE];
         end
         if (!tick)
            wait_ff <= wait_ff - 24'h000001;
         case (state_ff)
            // first cycle after reset release or soft reset: pick the boot source
            ST_BOOT: begin
               if (i_boot_sel) begin
                  state_ff <= ST_LOAD;
                  reset_load_ff <= 1'b1;
                  wait_ff <= P_LOAD_BYTE_CYC - 24'h000001;
                  err_ff <= 1'b0;
                  cal_ff <= 1'b0;
                  phase_ff <= 2'd0;
                  nptr_ff <= 10'h000;
               end else begin
                  state_ff <= ST_DEFW;
                  defl_ff <= 1'b1;
                  wait_ff <= DEF_CYC - 24'h000001;
               end
            end
            // defaults take effect; outputs start after a short wait
            ST_DEFW: begin
               if (tick) begin
                  state_ff <= ST_IDLE;
                  align_ff <= 1'b1;
                  outputs_on_ff <= 1'b1;
               end
            end
            ST_IDLE: begin
               if (i_soft_reset) begin
                  state_ff <= ST_BOOT;
                  outputs_on_ff <= 1'b0;
               end else if (softld_req) begin
                  state_ff <= ST_LOAD;
                  reset_load_ff <= 1'b0;
                  wait_ff <= P_LOAD_BYTE_CYC - 24'h000001;
                  err_ff <= 1'b0;
                  cal_ff <= 1'b0;
                  phase_ff <= 2'd0;
                  nptr_ff <= 10'h000;
               end else if (save_ff && !wen_ff) begin
                  // save refused without write enable
                  save_ff <= 1'b0;
                  err_ff <= 1'b1;
               end else if (save_ff && (!resume_ff || i_commit)) begin
                  state_ff <= ST_SAVE;
                  wait_ff <= P_SAVE_BYTE_CYC - 24'h000001;
                  err_ff <= 1'b0;
                  phase_ff <= 2'd0;
                  sidx_ff <= 5'h00;
                  if (!resume_ff)
                     nptr_ff <= 10'h000;
                  resume_ff <= 1'b0;
               end
            end
            // walk the segment, writing entries and register bytes
            ST_SAVE: begin
               if (sv_step) begin
                  wait_ff <= byte_cyc - 24'h000001;
                  if (nvm_full || (phase_ff == 2'd0 &&
                      (sidx_ff == SEG_TOP || kind == K_BAD))) begin
                     state_ff <= ST_IDLE;
                     err_ff <= 1'b1;
                     save_ff <= 1'b0;
                  end else begin
                     nptr_ff <= nptr_ff + 10'h001;
                     if (phase_ff == 2'd3) begin
                        nvm_mem[nptr_ff[8:0]] <= i_cfg_rdata;
                        raddr_ff <= raddr_ff + 16'h0001;
                        cnt_ff <= cnt_ff - 7'h01;
                        if (cnt_ff == 7'h00)
                           phase_ff <= 2'd0;
                     end else begin
                        nvm_mem[nptr_ff[8:0]] <= sv_seg;
                        sidx_ff <= sidx_ff + 5'h01;
                        case (phase_ff)
                           2'd0: begin
                              cnt_ff <= sv_seg[6:0];
                              if (kind == K_GRP)
                                 phase_ff <= 2'd1;
                              if (kind == K_END) begin
                                 state_ff <= ST_IDLE;
                                 save_ff <= 1'b0;
                              end
                              if (kind == K_PEND) begin
                                 state_ff <= ST_IDLE;
                                 save_ff <= 1'b0;
                                 resume_ff <= 1'b1;
                              end
                           end
                           2'd1: begin
                              raddr_ff[15:8] <= sv_seg;
                              phase_ff <= 2'd2;
                           end
                           default: begin
                              raddr_ff[7:0] <= sv_seg;
                              phase_ff <= 2'd3;
                           end
                        endcase
                     end
                  end
               end
            end
            // walk the stored image, feeding register writes
            ST_LOAD: begin
               if (ld_step) begin
                  wait_ff <= byte_cyc - 24'h000001;
                  nptr_ff <= nptr_ff + 10'h001;
                  if (nvm_full || (phase_ff == 2'd0 && kind == K_BAD)) begin
                     state_ff <= ST_IDLE;
                     err_ff <= 1'b1;
                     if (reset_load_ff) begin
                        align_ff <= 1'b1;
                        outputs_on_ff <= 1'b1;
                     end
                  end else begin
                     case (phase_ff)
                        2'd0: begin
                           cnt_ff <= ld_byte[6:0];
                           if (kind == K_GRP)
                              phase_ff <= 2'd1;
                           if (kind == K_COMMIT)
                              commit_ff <= 1'b1;
                           if (kind == K_END) begin
                              state_ff <= ST_IDLE;
                              cal_start_ff <= cal_ff;
                              if (reset_load_ff) begin
                                 align_ff <= 1'b1;
                                 outputs_on_ff <= 1'b1;
                              end
                           end
                        end
                        2'd1: begin
                           raddr_ff[15:8] <= ld_byte;
                           phase_ff <= 2'd2;
                        end
                        2'd2: begin
                           raddr_ff[7:0] <= ld_byte;
                           phase_ff <= 2'd3;
                        end
                        default: begin
                           if (raddr_ff == `NCSR_CAL_ADDR)
                              cal_ff <= ld_byte[`NCSR_CAL_BIT];
                           raddr_ff <= raddr_ff + 16'h0001;
                           cnt_ff <= cnt_ff - 7'h01;
                           if (cnt_ff == 7'h00)
                              phase_ff <= 2'd0;
                        end
                     endcase
                  end
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // two-entry buffer toward the register bank
   // ----------------------------------------------------------------
   // a stalled bank holds the loader instead of dropping a byte
   always @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         fwp_ff <= 1'b0;
         frp_ff <= 1'b0;
         fcnt_ff <= 2'd0;
      end else begin
         if (fifo_push) begin
            fq_ff[fwp_ff] <= {raddr_ff, ld_byte};
            fwp_ff <= ~fwp_ff;
         end
         if (fifo_pop)
            frp_ff <= ~frp_ff;
         if (fifo_push && !fifo_pop)
            fcnt_ff <= fcnt_ff + 2'd1;
         else if (fifo_pop && !fifo_push)
            fcnt_ff <= fcnt_ff - 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // register readback
   // ----------------------------------------------------------------
   // during a transfer every read returns zero but the busy flag
   always @* begin
      rd_mux = `NCSR_RST_BYTE;
      if (i_reg_addr == `NCSR_REG_STATUS)
         rd_mux[`NCSR_BIT_BUSY] = busy;
      else if (!busy) begin
         if (in_seg)
            rd_mux = seg_ff[seg_off[4:0]];
         else if (i_reg_addr == `NCSR_REG_ERROR)
            rd_mux[`NCSR_BIT_ERR] = err_ff;
         else if (i_reg_addr == `NCSR_REG_WEN)
            rd_mux[`NCSR_BIT_WEN] = wen_ff;
         else if (i_reg_addr == `NCSR_REG_SAVE)
            rd_mux[`NCSR_BIT_SAVE] = save_ff;
      end
   end

   always @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         rdata_ff <= `NCSR_RST_BYTE;
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= i_reg_rd || i_reg_wr;
         if (i_reg_rd)
            rdata_ff <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_reg_rdata = rdata_ff;
   assign o_reg_ack = ack_ff;
   assign o_port_blocked = busy;
   assign o_i2c_addr_ack = !busy;
   assign o_first_status_output = i_first_status_output_sel ? busy :
                                  i_first_status_output_other;
   assign o_cfg_raddr = raddr_ff;
   assign o_cfg_wvalid = !fifo_empty;
   assign o_cfg_waddr = fq_ff[frp_ff][23:8];
   assign o_cfg_wdata = fq_ff[frp_ff][7:0];
   assign o_commit = commit_ff;
   assign o_load_defaults = defl_ff;
   assign o_phase_align = align_ff;
   assign o_cal_start = cal_start_ff;
   assign o_outputs_on = outputs_on_ff;

endmodule // ncsr_nvm_config_save_restore

//--- sim/ncsr_chk_sva.sv
// Purpose: port-level assertions for the save/restore block
// Assumes: one clock, synchronous active-low reset
// Notes: sees only top-level ports, attached by bind
module ncsr_chk_sva (
   input wire i_sys_clk,
   input wire i_rstn,
   input wire i_first_status_output_sel,
   input wire i_first_status_output_other,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [11:0] i_reg_addr,
   input wire [7:0] o_reg_rdata,
   input wire o_reg_ack,
   input wire o_port_blocked,
   input wire o_i2c_addr_ack,
   input wire o_first_status_output,
   input wire o_cfg_wvalid,
   input wire [15:0] o_cfg_waddr,
   input wire [7:0] o_cfg_wdata,
   input wire i_cfg_wready,
   input wire o_commit
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   // ----------------------------------------------------------------
   // register port, blocking and the load write stream
   // ----------------------------------------------------------------
   ack_after_req_a: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
      else $error("ack missing after request");
   ack_no_req_a: assert property (!(i_reg_wr || i_reg_rd) |=> !o_reg_ack)
      else $error("ack without request");
   busy_read_a: assert property (i_reg_rd && i_reg_addr == 12'hb00
      |=> o_reg_rdata == {7'h00, $past(o_port_blocked)})
      else $error("busy flag read wrong");
   blocked_zero_a: assert property (i_reg_rd && o_port_blocked &&
      i_reg_addr != 12'hb00 |=> o_reg_rdata == 8'h00)
      else $error("register readable while blocked");
   addr_nack_a: assert property (o_i2c_addr_ack == !o_port_blocked)
      else $error("address ack while busy");
   status_pin_a: assert property (o_first_status_output ==
      (i_first_status_output_sel ? o_port_blocked : i_first_status_output_other))
      else $error("status pin wrong");
   stall_hold_a: assert property (o_cfg_wvalid && !i_cfg_wready |=>
      o_cfg_wvalid && $stable(o_cfg_waddr) && $stable(o_cfg_wdata))
      else $error("buffer head lost in stall");
   commit_pulse_a: assert property (o_commit |=> !o_commit)
      else $error("commit longer than a cycle");
   write_busy_a: assert property (o_cfg_wvalid |-> o_port_blocked)
      else $error("bank write outside transfer");
   cover property (o_commit);
   cover property (o_cfg_wvalid && !i_cfg_wready);
   cover property ($fell(o_port_blocked));
endmodule // ncsr_chk_sva

bind ncsr_nvm_config_save_restore ncsr_chk_sva u_sva (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_first_status_output_sel(i_first_status_output_sel),
   .i_first_status_output_other(i_first_status_output_other), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
   .o_reg_ack(o_reg_ack), .o_port_blocked(o_port_blocked),
   .o_i2c_addr_ack(o_i2c_addr_ack),
   .o_first_status_output(o_first_status_output),
   .o_cfg_wvalid(o_cfg_wvalid), .o_cfg_waddr(o_cfg_waddr),
   .o_cfg_wdata(o_cfg_wdata), .i_cfg_wready(i_cfg_wready),
   .o_commit(o_commit));

//--- sim/ncsr_bank_model.sv
// Purpose: register bank on the far side of the store controller
// Assumes: bank value of a byte is a fixed function of its address
// Notes: slow mode takes one word in eight so the buffer fills
module ncsr_bank_model (
   input wire i_sys_clk,
   input wire i_clr,
   input wire i_slow,
   input wire [15:0] i_raddr,
   output logic [7:0] o_rdata,
   input wire i_wvalid,
   input wire [15:0] i_waddr,
   input wire [7:0] i_wdata,
   output logic o_wready,
   input wire i_commit,
   output logic [9:0] o_wr_cnt,
   output logic [9:0] o_bad_cnt,
   output logic [3:0] o_cmt_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cyc_ff = 3'h0;
   logic [16:0] last_ff;
   // pattern makes 0x0f3 carry bit 1, so calibration must follow a load
   assign o_rdata = i_raddr[7:0] ^ i_raddr[15:8];
   assign o_wready = !i_slow || (cyc_ff == 3'h0);
   // ----------------------------------------------------------------
   // accepted words: count, order and content
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      cyc_ff <= cyc_ff + 3'h1;
      if (i_clr) begin
         o_wr_cnt <= 10'h000;
         o_bad_cnt <= 10'h000;
         o_cmt_cnt <= 4'h0;
         last_ff <= 17'h10000;
      end else begin
         if (i_commit)
            o_cmt_cnt <= o_cmt_cnt + 4'h1;
         if (i_wvalid && o_wready) begin
            o_wr_cnt <= o_wr_cnt + 10'h001;
            last_ff <= {1'b0, i_waddr};
            if ((i_wdata !== (i_waddr[7:0] ^ i_waddr[15:8])) ||
               (!last_ff[16] && i_waddr <= last_ff[15:0]))
               o_bad_cnt <= o_bad_cnt + 10'h001;
         end
      end
   end
endmodule // ncsr_bank_model

//--- sim/ncsr_tb.sv
// Purpose: self-checking bench for the store save/restore block
// Assumes: byte costs shortened to 4 cycles
// Notes: register tasks wait the one-cycle answer of the port
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic boot = 1'b0, srst = 1'b0, ssel = 1'b0, soth = 1'b1;
   logic wr = 1'b0, rd = 1'b0, mclr = 1'b1, slow = 1'b0, cin = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdat = 8'h00, rdat;
   wire [7:0] rdata, cfg_rd, cwd;
   wire ack, blk, iack, st0, cwv, cwr, cmt, ldef, pa, cal, on;
   wire [15:0] cra, cwa;
   wire [9:0] wcnt, bcnt;
   wire [3:0] ccnt;
   int err_total = 0, checks = 0, cyc = 0, n, t0, pa_n = 0, cal_n = 0;
   int ld_n = 0;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("BAD %0t got %0h exp %0h", $time, a, b); end end

   ncsr_nvm_config_save_restore #(.P_SAVE_BYTE_CYC(24'd4),
      .P_LOAD_BYTE_CYC(24'd4)) u_dut (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_boot_sel(boot),
      .i_soft_reset(srst), .i_commit(cin), .i_first_status_output_sel(ssel),
      .i_first_status_output_other(soth), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdata),
      .o_reg_ack(ack), .o_port_blocked(blk), .o_i2c_addr_ack(iack),
      .o_first_status_output(st0), .o_cfg_raddr(cra), .i_cfg_rdata(cfg_rd),
      .o_cfg_wvalid(cwv), .o_cfg_waddr(cwa), .o_cfg_wdata(cwd),
      .i_cfg_wready(cwr), .o_commit(cmt), .o_load_defaults(ldef),
      .o_phase_align(pa), .o_cal_start(cal), .o_outputs_on(on));
   ncsr_bank_model u_bank (.i_sys_clk(i_sys_clk), .i_clr(mclr),
      .i_slow(slow), .i_raddr(cra), .o_rdata(cfg_rd), .i_wvalid(cwv),
      .i_waddr(cwa), .i_wdata(cwd), .o_wready(cwr), .i_commit(cmt),
      .o_wr_cnt(wcnt), .o_bad_cnt(bcnt), .o_cmt_cnt(ccnt));

   initial forever #2.5 i_sys_clk = ~i_sys_clk;
   // ----------------------------------------------------------------
   // pulse counters and hang guard
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (pa === 1'b1) pa_n <= pa_n + 1;
      if (cal === 1'b1) cal_n <= cal_n + 1;
      if (ldef === 1'b1) ld_n <= ld_n + 1;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      wr <= 1'b1; addr <= a; wdat <= d;
      @(posedge i_sys_clk);
      wr <= 1'b0;
      #1 `CHK(ack, 1'b1)
   endtask
   task automatic rreg(input logic [11:0] a);
      @(posedge i_sys_clk);
      rd <= 1'b1; addr <= a;
      @(posedge i_sys_clk);
      rd <= 1'b0;
      #1 rdat = rdata;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      rreg(a);
      `CHK({ack, rdat}, {1'b1, e})
   endtask
   // poll the busy flag; reads are the only legal access while busy
   task automatic idle;
      int k = 0;
      rchk(12'hb00, 8'h01);
      while (rdat[0] !== 1'b0 && k < 3000) begin
         rreg(12'hb00);
         k++;
      end
      `CHK({ack, rdat}, 9'h100)
   endtask
   task automatic wait_on(input int lim);
      n = 0;
      while (on !== 1'b1 && n < lim) begin
         @(posedge i_sys_clk);
         n++;
      end
      // let the pulse counters of this edge settle before checks
      #1;
   endtask
   task automatic results;
      $display("mismatches %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // boot to defaults, save with a pseudo end and resume, then loads
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_rstn <= 1'b1; mclr <= 1'b0;
      wait_on(500);
      `CHK(n >= 400 && n <= 410, 1'b1)
      `CHK(pa_n, 1)
      rchk(12'hb00, 8'h00);
      rchk(12'hc00, 8'h00);
      wreg(12'hb03, 8'h01);
      rchk(12'hb03, 8'h00);
      rchk(12'hb01, 8'h01);
      @(posedge i_sys_clk) ssel <= 1'b1;
      wreg(12'ha10, 8'hfe);
      wreg(12'hb02, 8'h01);
      wreg(12'hb03, 8'h01);
      t0 = cyc;
      rchk(12'hb00, 8'h01);
      `CHK({blk, iack, st0}, 3'b101)
      wreg(12'hb02, 8'h00);
      idle();
      `CHK(cyc - t0 >= 1990 && cyc - t0 <= 2070, 1'b1)
      wreg(12'ha00, 8'hff);
      wreg(12'hb03, 8'h01);
      rchk(12'hb03, 8'h01);
      @(posedge i_sys_clk) cin <= 1'b1;
      @(posedge i_sys_clk) cin <= 1'b0;
      idle();
      rchk(12'hb03, 8'h00);
      rchk(12'hb01, 8'h00);
      rchk(12'hb02, 8'h01);
      wreg(12'hb02, 8'h00);
      `CHK(iack, 1'b1)
      @(posedge i_sys_clk) begin slow <= 1'b1; mclr <= 1'b1; end
      @(posedge i_sys_clk) mclr <= 1'b0;
      wreg(12'hb02, 8'h02);
      idle();
      `CHK({wcnt, bcnt, ccnt}, {10'd485, 10'd0, 4'd1})
      `CHK(cal_n, 1)
      @(posedge i_sys_clk) begin i_rstn <= 1'b0; boot <= 1'b1; end
      @(posedge i_sys_clk) begin mclr <= 1'b1; slow <= 1'b0; end
      @(posedge i_sys_clk) begin i_rstn <= 1'b1; mclr <= 1'b0; end
      t0 = cyc;
      repeat (3) @(posedge i_sys_clk);
      #1 `CHK(blk, 1'b1)
      wait_on(5000);
      `CHK(cyc - t0 >= 2000 && cyc - t0 <= 2100, 1'b1)
      `CHK({wcnt, bcnt, ccnt}, {10'd485, 10'd0, 4'd1})
      `CHK({pa_n, ld_n}, {32'd2, 32'd1})
      @(posedge i_sys_clk) begin srst <= 1'b1; mclr <= 1'b1; end
      @(posedge i_sys_clk) begin srst <= 1'b0; mclr <= 1'b0; end
      repeat (3) @(posedge i_sys_clk);
      #1 `CHK(blk, 1'b1)
      idle();
      `CHK({wcnt, bcnt}, {10'd485, 10'd0})
      results();
   end
endmodule // testbench
